/* File: rtl/bmc_rx_classifier_pkg.sv */
// Package for the receive pulse-width classifier.
// Assumes byte-wide management registers reached by a 16-bit address.
package bmc_rx_classifier_pkg;

    localparam int          ADDR_W   = 16;
    localparam int          DATA_W   = 8;
    localparam int          NUM_REGS = 8;

    // Register addresses
    localparam logic [15:0] HI_FB_MAX_ADDR = 16'h1aa0;
    localparam logic [15:0] HI_FB_MIN_ADDR = 16'h1aa1;
    localparam logic [15:0] LO_FB_MAX_ADDR = 16'h1aa2;
    localparam logic [15:0] LO_FB_MIN_ADDR = 16'h1aa3;
    localparam logic [15:0] HI_HB_MAX_ADDR = 16'h1aa4;
    localparam logic [15:0] HI_HB_MIN_ADDR = 16'h1aa5;
    localparam logic [15:0] LO_HB_MAX_ADDR = 16'h1aa6;
    localparam logic [15:0] LO_HB_MIN_ADDR = 16'h1aa7;

    // Register indices within the threshold bank
    localparam logic [2:0]  HI_FB_MAX_IDX = 3'h0;
    localparam logic [2:0]  HI_FB_MIN_IDX = 3'h1;
    localparam logic [2:0]  LO_FB_MAX_IDX = 3'h2;
    localparam logic [2:0]  LO_FB_MIN_IDX = 3'h3;
    localparam logic [2:0]  HI_HB_MAX_IDX = 3'h4;
    localparam logic [2:0]  HI_HB_MIN_IDX = 3'h5;
    localparam logic [2:0]  LO_HB_MAX_IDX = 3'h6;
    localparam logic [2:0]  LO_HB_MIN_IDX = 3'h7;

    localparam logic [7:0]  THRESH_RESET  = 8'h00;
    localparam logic [7:0]  RDATA_UNMAPPED = 8'h00;

    // Software programming guidance, not used by hardware
    localparam logic [7:0]  REC_FB_MAX = 8'hca;
    localparam logic [7:0]  REC_FB_MIN = 8'h74;
    localparam logic [7:0]  REC_HB_MAX = 8'h6e;
    localparam logic [7:0]  REC_HB_MIN = 8'h30;

    // Interval length counter
    localparam logic [7:0]  LEN_SAT    = 8'hff;
    localparam logic [7:0]  LEN_FIRST  = 8'h01;
    localparam logic [7:0]  LEN_RESET  = 8'h00;

    typedef struct packed {
        logic                wr;
        logic                rd;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } reg_req_s;

    typedef struct packed {
        logic valid;
        logic value;
    } rx_bit_s;

    typedef enum logic [1:0] {CLASS_NONE, CLASS_HALF, CLASS_FULL} interval_class_e;

endpackage

/* File: rtl/bmc_rx_pulse_width_classifier.sv */
// Receive pulse-width classifier and bit former for a biphase mark line.
// Assumes rx_level_i is already synchronous to sys_clk_i and deglitched.
//
// Operation
// - High interval is full bit only strictly between high full min and max.
// - Low interval is full bit only strictly between low full min and max.
// - High interval is half bit only strictly between high half min and max.
// - Low interval is half bit only strictly between low half min and max.
// - High full-bit maximum: 8-bit cycle count, suggested 202.
// - High full-bit minimum: 8-bit cycle count, suggested 116.
// - Low full-bit maximum: 8-bit cycle count, suggested 202.
// - Low full-bit minimum: 8-bit cycle count, suggested 116.
// - High half-bit maximum: 8-bit cycle count, suggested 110.
// - High half-bit minimum: 8-bit cycle count, suggested 48.
// - Low half-bit maximum: 8-bit cycle count, suggested 110.
// - Low half-bit minimum: 8-bit cycle count, suggested 48.
`timescale 1ns/100ps

module bmc_rx_pulse_width_classifier
    import bmc_rx_classifier_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire reg_req_s          reg_req_i,
    output logic [DATA_W-1:0]      reg_rdata_o,
    input  wire logic              rx_level_i,
    output rx_bit_s                rx_bit_o,
    output logic                   interval_error_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Threshold bank

    logic [7:0]      thresh [NUM_REGS];
    logic            addr_hit;
    logic [2:0]      addr_idx;

    function automatic logic in_window(input logic [7:0] len,
                                       input logic [7:0] lo,
                                       input logic [7:0] hi);
        in_window = (len > lo) && (len < hi);
    endfunction

    // Bank occupies a contiguous block of eight byte addresses
    assign addr_hit = (reg_req_i.addr >= HI_FB_MAX_ADDR) && (reg_req_i.addr <= LO_HB_MIN_ADDR);
    assign addr_idx = reg_req_i.addr[2:0];

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
                thresh[i] <= THRESH_RESET;
            end
        end
        else if (reg_req_i.wr && addr_hit)
        begin
            thresh[addr_idx] <= reg_req_i.wdata;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= RDATA_UNMAPPED;
        end
        else if (reg_req_i.rd)
        begin
            reg_rdata_o <= addr_hit ? thresh[addr_idx] : RDATA_UNMAPPED;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interval measurement

    logic            rx_prev;
    logic            armed;
    logic [7:0]      len;
    logic            edge_seen;

    assign edge_seen = rx_level_i != rx_prev;

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            rx_prev <= 1'b0;
        end
        else
        begin
            rx_prev <= rx_level_i;
        end
    end

    // First interval after reset has no known start, so it is never judged
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            armed <= 1'b0;
        end
        else if (edge_seen)
        begin
            armed <= 1'b1;
        end
    end

    // Saturation keeps overlong levels outside every 8-bit window
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            len <= LEN_RESET;
        end
        else if (edge_seen)
        begin
            len <= LEN_FIRST;
        end
        else if (len != LEN_SAT)
        begin
            len <= len + LEN_FIRST;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Classification

    logic            hi_full;
    logic            lo_full;
    logic            hi_half;
    logic            lo_half;
    interval_class_e next_class;

    assign hi_full = in_window(len, thresh[HI_FB_MIN_IDX], thresh[HI_FB_MAX_IDX]);
    assign lo_full = in_window(len, thresh[LO_FB_MIN_IDX], thresh[LO_FB_MAX_IDX]);
    assign hi_half = in_window(len, thresh[HI_HB_MIN_IDX], thresh[HI_HB_MAX_IDX]);
    assign lo_half = in_window(len, thresh[LO_HB_MIN_IDX], thresh[LO_HB_MAX_IDX]);

    // Full window wins if software lets the windows overlap
    always_comb
    begin
        next_class = CLASS_NONE;
        if (rx_prev ? hi_full : lo_full)
        begin
            next_class = CLASS_FULL;
        end
        else if (rx_prev ? hi_half : lo_half)
        begin
            next_class = CLASS_HALF;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit forming

    logic            half_pending;
    logic            judge;

    assign judge = edge_seen && armed;

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            half_pending     <= 1'b0;
            rx_bit_o         <= '0;
            interval_error_o <= 1'b0;
        end
        else
        begin
            rx_bit_o         <= '0;
            interval_error_o <= 1'b0;
            if (judge)
            begin
                case (next_class)
                    CLASS_FULL:
                    begin
                        rx_bit_o     <= '{valid: 1'b1, value: 1'b0};
                        half_pending <= 1'b0;
                    end
                    CLASS_HALF:
                    begin
                        if (half_pending)
                        begin
                            rx_bit_o <= '{valid: 1'b1, value: 1'b1};
                        end
                        half_pending <= !half_pending;
                    end
                    default:
                    begin
                        interval_error_o <= 1'b1;
                        half_pending     <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    high_full_a: assert property (
        judge && rx_prev && hi_full
        |=> rx_bit_o.valid && !rx_bit_o.value)
        else $error("High full interval not decoded as zero");

    low_full_a: assert property (
        judge && !rx_prev && lo_full
        |=> rx_bit_o.valid && !rx_bit_o.value)
        else $error("Low full interval not decoded as zero");

    high_half_a: assert property (
        judge && rx_prev && hi_half && !hi_full
        |=> half_pending != $past(half_pending))
        else $error("High half interval not counted");

    low_half_a: assert property (
        judge && !rx_prev && lo_half && !lo_full
        |=> half_pending != $past(half_pending))
        else $error("Low half interval not counted");

    high_full_bound_a: assert property (
        judge && rx_prev && next_class == CLASS_FULL
        |-> (len > thresh[HI_FB_MIN_IDX]) && (len < thresh[HI_FB_MAX_IDX]))
        else $error("High full accepted outside its window");

    low_full_bound_a: assert property (
        judge && !rx_prev && next_class == CLASS_FULL
        |-> (len > thresh[LO_FB_MIN_IDX]) && (len < thresh[LO_FB_MAX_IDX]))
        else $error("Low full accepted outside its window");

    high_half_bound_a: assert property (
        judge && rx_prev && next_class == CLASS_HALF
        |-> (len > thresh[HI_HB_MIN_IDX]) && (len < thresh[HI_HB_MAX_IDX]))
        else $error("High half accepted outside its window");

    low_half_bound_a: assert property (
        judge && !rx_prev && next_class == CLASS_HALF
        |-> (len > thresh[LO_HB_MIN_IDX]) && (len < thresh[LO_HB_MAX_IDX]))
        else $error("Low half accepted outside its window");

    len_count_a: assert property (
        !edge_seen && len != LEN_SAT
        |=> len == $past(len) + LEN_FIRST)
        else $error("Interval length did not advance");

    len_restart_a: assert property (
        edge_seen
        |=> len == LEN_FIRST)
        else $error("Interval length did not restart");

    len_sat_a: assert property (
        !edge_seen && len == LEN_SAT
        |=> len == LEN_SAT)
        else $error("Interval length wrapped");

    invalid_drop_a: assert property (
        judge && next_class == CLASS_NONE
        |=> interval_error_o && !rx_bit_o.valid && !half_pending)
        else $error("Invalid interval produced a bit");

    one_pair_a: assert property (
        rx_bit_o.valid && rx_bit_o.value
        |-> $past(half_pending) && $past(judge))
        else $error("One emitted without a half pair");

    half_first_a: assert property (
        judge && next_class == CLASS_HALF && !half_pending
        |=> !rx_bit_o.valid && half_pending)
        else $error("Lone half interval emitted a bit");

    full_clears_a: assert property (
        judge && next_class == CLASS_FULL
        |=> !half_pending)
        else $error("Full interval left a half pending");

    bit_source_a: assert property (
        !judge
        |=> !rx_bit_o.valid && !interval_error_o)
        else $error("Bit emitted without an edge");

    reg_store_a: assert property (
        reg_req_i.wr && reg_req_i.addr == HI_FB_MAX_ADDR
        |=> thresh[HI_FB_MAX_IDX] == $past(reg_req_i.wdata))
        else $error("Threshold write lost");

    reg_read_a: assert property (
        reg_req_i.rd && !reg_req_i.wr && reg_req_i.addr == LO_HB_MIN_ADDR
        |=> reg_rdata_o == thresh[LO_HB_MIN_IDX])
        else $error("Threshold readback wrong");

    unmapped_read_a: assert property (
        reg_req_i.rd && !addr_hit
        |=> reg_rdata_o == RDATA_UNMAPPED)
        else $error("Unmapped read returned data");

    rdata_hold_a: assert property (
        !reg_req_i.rd
        |=> $stable(reg_rdata_o))
        else $error("Read data changed without a read");

    zero_bit_c: cover property (rx_bit_o.valid && !rx_bit_o.value);
    one_bit_c: cover property (rx_bit_o.valid && rx_bit_o.value);
    bad_interval_c: cover property (interval_error_o);
    half_open_c: cover property (judge && next_class == CLASS_HALF && !half_pending);
    len_sat_c: cover property (len == LEN_SAT);

endmodule

/* File: test/bmc_remote_port_model.sv */
// Far port model: drives the received baseband level in intervals.
// Assumes the bench calls send with interval lengths in clock cycles.
`timescale 1ns/100ps

module bmc_remote_port_model
(
    input  wire logic sys_clk_i,
    output logic      rx_level_o
);

    initial rx_level_o = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Toggle, then hold n-1 more edges so the receiver counts exactly n cycles
    task automatic send(input int n);
        @(posedge sys_clk_i);
        rx_level_o <= ~rx_level_o;
        repeat (n - 1) @(posedge sys_clk_i);
    endtask

endmodule

/* File: test/tb.sv */
// Bench for the receive pulse-width classifier.
// Assumes one 20 MHz clock and a synchronous active-high reset.
`timescale 1ns/100ps

module tb;
    import bmc_rx_classifier_pkg::*;

    logic       sys_clk_i = 1'b0;
    logic       rst_i     = 1'b1;
    reg_req_s   reg_req_i = '0;
    logic [7:0] reg_rdata_o;
    logic       rx_level;
    rx_bit_s    rx_bit_o;
    logic       interval_error_o;
    int         mismatches      = 0;
    int         samples_checked = 0;
    int         errs            = 0;
    logic       bits[$];
    // Low windows differ from high ones so swapped registers show up
    logic [7:0] vals[8] = '{8'hca, 8'h74, 8'hbe, 8'h78, 8'h6e, 8'h30, 8'h64, 8'h32};
    int         lens[15] = '{20, 201, 121, 49, 99, 116, 190, 48, 50, 110, 120,
                             80, 150, 60, 60};
    // Lone half before a full is dropped, so only the final pair gives a one
    logic       exp_bits[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

    always #25 sys_clk_i = ~sys_clk_i;

    bmc_rx_pulse_width_classifier uut
    (
        .sys_clk_i        (sys_clk_i),
        .rst_i            (rst_i),
        .reg_req_i        (reg_req_i),
        .reg_rdata_o      (reg_rdata_o),
        .rx_level_i       (rx_level),
        .rx_bit_o         (rx_bit_o),
        .interval_error_o (interval_error_o)
    );

    bmc_remote_port_model peer
    (
        .sys_clk_i  (sys_clk_i),
        .rx_level_o (rx_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pulses last one cycle, so collect them as they pass
    always @(posedge sys_clk_i)
    begin
        if (!rst_i && rx_bit_o.valid === 1'b1)
            bits.push_back(rx_bit_o.value);
        if (!rst_i && interval_error_o === 1'b1)
            errs++;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk_i);
        reg_req_i <= '0;
    endtask

    task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        reg_req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk_i);
        reg_req_i <= '0;
        @(posedge sys_clk_i);
        #1;
        check(reg_rdata_o, exp);
    endtask

    task automatic final_report;
        $display("compares=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Run is under 2000 cycles; the limit leaves wide margin
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        mismatches++;
        final_report();
    end

    initial
    begin
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd_reg(HI_FB_MAX_ADDR + 16'(i), 8'h00);
        for (int i = 0; i < 8; i++)
            wr_reg(HI_FB_MAX_ADDR + 16'(i), vals[i]);
        for (int i = 0; i < 8; i++)
            rd_reg(HI_FB_MAX_ADDR + 16'(i), vals[i]);
        wr_reg(16'h1aa8, 8'hff);
        rd_reg(16'h1aa8, 8'h00);
        rd_reg(16'h1a9f, 8'h00);
        // Long idle saturates the length counter before the first edge
        repeat (300) @(posedge sys_clk_i);
        // First send ends the unjudged interval; polarity then alternates
        foreach (lens[i])
            peer.send(lens[i]);
        peer.send(5);
        repeat (4) @(posedge sys_clk_i);
        check(8'(bits.size()), 8'h05);
        for (int i = 0; i < 5 && i < bits.size(); i++)
            check({7'h00, bits[i]}, {7'h00, exp_bits[i]});
        check(8'(errs), 8'h06);
        final_report();
    end

endmodule
